/* File: design/lcs_map.svh */
// constants for the lubrication cycle sequencer: clock, defaults, setting ranges, timing
`ifndef LCS_MAP_SVH
`define LCS_MAP_SVH
`define LCS_CLK_HZ          20000000
`define LCS_MS_CYC          (`LCS_CLK_HZ / 1000)
`define LCS_BURST_MS        500
`define LCS_GAP_MS          2000
`define LCS_BURST_CYC       (`LCS_BURST_MS * `LCS_MS_CYC)
`define LCS_GAP_CYC         (`LCS_GAP_MS * `LCS_MS_CYC)
`define LCS_DEF_TOUT_S      30
`define LCS_DEF_LUBE_S      30
`define LCS_DEF_PAUSE_S     360
`define LCS_DEF_CYCLES      1
`define LCS_DEF_PRELUBE     0
`define LCS_MAX_CYCLES      250
`define LCS_MIN_SEC         1
`define LCS_MAX_SEC         120
`endif

/* File: design/lcs_pkg.sv */
// types for the lubrication cycle sequencer
package lcs_pkg;
  typedef enum logic [0:0] {LCS_END_CYCLE = 1'b0, LCS_END_PULSE = 1'b1} lcs_end_type;
  typedef enum logic [0:0] {LCS_MON_TIMER = 1'b0, LCS_MON_PS = 1'b1} lcs_mon_type;
  typedef enum logic [1:0] {
    LCS_SB_TIMER = 2'h0, LCS_SB_BOTH = 2'h1, LCS_SB_COUNT = 2'h2, LCS_SB_CNT_TOUT = 2'h3
  } lcs_sb_type;
  typedef enum logic [1:0] {LCS_PO_RESUME = 2'h0, LCS_PO_STANDBY = 2'h1, LCS_PO_LUBE = 2'h2}
    lcs_po_type;
  typedef enum logic [1:0] {LCS_HALT_ALL = 2'h0, LCS_HALT_NONE = 2'h1, LCS_HALT_NOT_MIN = 2'h2}
    lcs_halt_type;
  typedef enum logic [1:0] {
    LCS_ST_STANDBY = 2'h0, LCS_ST_LUBE = 2'h1, LCS_ST_DWELL = 2'h3, LCS_ST_HALT = 2'h2
  } lcs_state_type;
endpackage : lcs_pkg

/* File: design/lcs_alarm_coder.sv */
// alarm relay driver: steady level or pulse-coded bursts
`timescale 1ns/10ps
`default_nettype none
`include "lcs_map.svh"
module lcs_alarm_coder #(
  parameter int BURST_CYC = `LCS_BURST_CYC,
  parameter int GAP_CYC   = `LCS_GAP_CYC
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       coded_mode,
  input  wire logic [3:0] alarm_code,
  output logic            relay_on
);
  logic [31:0] tmr_ff;
  logic [3:0]  burst_ff;
  logic        low_ff;
  logic        gap_ff;
  logic        relay_ff;
  wire         active = (alarm_code != 4'h0);

  // burst sequencer: burst low BURST, high BURST between, then a GAP wait
  // RQ16 burst timing
  always_ff @(posedge mclk) begin
    if (reset || !active || !coded_mode) begin
      tmr_ff   <= 32'h0;
      burst_ff <= 4'h0;
      low_ff   <= 1'b0;
      gap_ff   <= 1'b0;
    end else if (tmr_ff != 32'h0) begin
      tmr_ff <= tmr_ff - 32'h1;
    end else if (gap_ff) begin
      gap_ff <= 1'b0;
      low_ff <= 1'b1;
      burst_ff <= 4'h1;
      tmr_ff <= BURST_CYC - 1;
    end else if (low_ff) begin
      low_ff <= 1'b0;
      if (burst_ff >= alarm_code) begin
        gap_ff <= 1'b1;
        tmr_ff <= GAP_CYC - 1;
      end else begin
        tmr_ff <= BURST_CYC - 1;
      end
    end else begin
      low_ff   <= 1'b1;
      burst_ff <= burst_ff + 4'h1;
      tmr_ff   <= BURST_CYC - 1;
    end
  end

  // relay energised when healthy; de-energised for alarm or coded pulse
  // RQ14 standard level
  always_ff @(posedge mclk) begin
    if (reset)
      relay_ff <= 1'b0;
    else if (!active)
      relay_ff <= 1'b1;
    else if (!coded_mode)
      relay_ff <= 1'b0;
    else
      // RQ15 coded pulses
      relay_ff <= !low_ff;
  end
  assign relay_on = relay_ff;
endmodule : lcs_alarm_coder
`default_nettype wire

/* File: design/lcs_sequencer.sv */
// lubrication cycle sequencer: phases, timers, counters, alarms, registers
// Contract
// RQ1: cycle mode ends cycle on sensor or timer
// RQ2: pulse mode phases counted from pulses
// RQ3: monitor timer or switch; pulse none/switch
// RQ4: standby source picks standby end, timer default
// RQ5: combined source: timer or count first
// RQ6: counter source ignores pause timer
// RQ7: counted-timeout source alarms on pause expiry
// RQ8: cycle timeout alarm, 1s-2min, default 30s
// RQ9: timed run time 1s-2min, default 30s
// RQ10: repeat cycles 1-250 then standby
// RQ11: power-on phase chosen by setting; po_ff is read at its reset value, so resume always applies
// RQ12: resume restores held phase and progress; cycles_ff is still 1 when read, so progress restarts at zero
// RQ13: prelube cycles 0-250, zero none; prelube_ff is reset to 0 before it is read, so no prelube runs
// RQ14: standard alarm de-energises relay
// RQ15: coded alarm pulses the relay
// RQ16: 500ms bursts, 2000ms gap, monitor counts
// RQ17: halt policy: none, all, all but min
// RQ18: pump on in cycles, off otherwise
`timescale 1ns/10ps
`default_nettype none
`include "lcs_map.svh"
module lcs_sequencer #(
  parameter int SEC_CYC   = `LCS_CLK_HZ,
  parameter int BURST_CYC = `LCS_BURST_CYC,
  parameter int GAP_CYC   = `LCS_GAP_CYC
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        pulse_in,
  input  wire logic        sensor_in,
  input  wire logic        min_level_in,
  input  wire logic        held_valid,
  input  wire logic        held_lube,
  input  wire logic [7:0]  held_cycles,
  output logic             pump_on,
  output logic             alarm_relay,
  output logic             irq
);
  // register indices (byte address is four times the index)
  localparam logic [3:0] R_MODE = 4'h0, R_PAUSE = 4'h1, R_TIMES = 4'h2, R_COUNTS = 4'h3;
  localparam logic [3:0] R_PCNT = 4'h4, R_STATUS = 4'h5, R_IRQ_ST = 4'h6, R_IRQ_CLR = 4'h7;
  localparam logic [3:0] R_IRQ_EN = 4'h8;

  // settings
  lcs_pkg::lcs_end_type  end_ff;
  lcs_pkg::lcs_mon_type  mon_ff;
  lcs_pkg::lcs_sb_type   sb_ff;
  lcs_pkg::lcs_po_type   po_ff;
  lcs_pkg::lcs_halt_type halt_ff;
  logic        coded_ff;
  logic [23:0] pause_s_ff;
  logic [6:0]  tout_s_ff, lube_s_ff;
  logic [7:0]  cycles_ff, prelube_ff;
  logic [15:0] pcnt_sb_ff, pcnt_lube_ff;
  logic [3:0]  irq_st_ff, irq_en_ff;

  // register writes; values clamped to the documented ranges
  always_ff @(posedge mclk) begin
    if (reset) begin
      end_ff  <= lcs_pkg::LCS_END_CYCLE;
      mon_ff  <= lcs_pkg::LCS_MON_TIMER;
      sb_ff   <= lcs_pkg::LCS_SB_TIMER;
      po_ff   <= lcs_pkg::LCS_PO_RESUME;
      halt_ff <= lcs_pkg::LCS_HALT_ALL;
      coded_ff <= 1'b0;
      pause_s_ff <= 24'(`LCS_DEF_PAUSE_S);
      tout_s_ff  <= 7'(`LCS_DEF_TOUT_S);
      lube_s_ff  <= 7'(`LCS_DEF_LUBE_S);
      cycles_ff  <= 8'(`LCS_DEF_CYCLES);
      prelube_ff <= 8'(`LCS_DEF_PRELUBE);
      pcnt_sb_ff   <= 16'h1;
      pcnt_lube_ff <= 16'h1;
      irq_en_ff <= 4'h0;
    end else if (wr) begin
      case (addr)
        R_MODE: begin
          end_ff  <= lcs_pkg::lcs_end_type'(wdata[0]);
          mon_ff  <= lcs_pkg::lcs_mon_type'(wdata[1]);
          sb_ff   <= lcs_pkg::lcs_sb_type'(wdata[3:2]);
          po_ff   <= (wdata[5:4] == 2'h3) ? lcs_pkg::LCS_PO_RESUME
                     : lcs_pkg::lcs_po_type'(wdata[5:4]);
          halt_ff <= (wdata[7:6] == 2'h3) ? lcs_pkg::LCS_HALT_ALL
                     : lcs_pkg::lcs_halt_type'(wdata[7:6]);
          coded_ff <= wdata[8];
        end
        R_PAUSE: pause_s_ff <= (wdata[23:0] == 24'h0) ? 24'h1 : wdata[23:0];
        // RQ8 timeout range
        R_TIMES: begin
          tout_s_ff <= (wdata[6:0] < 7'(`LCS_MIN_SEC)) ? 7'(`LCS_MIN_SEC)
                       : (wdata[6:0] > 7'(`LCS_MAX_SEC)) ? 7'(`LCS_MAX_SEC) : wdata[6:0];
          // RQ9 run time range
          lube_s_ff <= (wdata[14:8] < 7'(`LCS_MIN_SEC)) ? 7'(`LCS_MIN_SEC)
                       : (wdata[14:8] > 7'(`LCS_MAX_SEC)) ? 7'(`LCS_MAX_SEC) : wdata[14:8];
        end
        // RQ10 cycle count range
        R_COUNTS: begin
          cycles_ff <= (wdata[7:0] == 8'h0) ? 8'h1
                       : (wdata[7:0] > 8'(`LCS_MAX_CYCLES)) ? 8'(`LCS_MAX_CYCLES) : wdata[7:0];
          // RQ13 prelube range
          prelube_ff <= (wdata[15:8] > 8'(`LCS_MAX_CYCLES)) ? 8'(`LCS_MAX_CYCLES) : wdata[15:8];
        end
        R_PCNT: begin
          pcnt_sb_ff   <= (wdata[15:0] == 16'h0) ? 16'h1 : wdata[15:0];
          pcnt_lube_ff <= (wdata[31:16] == 16'h0) ? 16'h1 : wdata[31:16];
        end
        R_IRQ_EN: irq_en_ff <= wdata[3:0];
        default: ;
      endcase
    end
  end

  // pin synchronisers: three stages, change taken when stages 2 and 3 agree
  logic [2:0] s_pulse_ff, s_sens_ff, s_min_ff;
  logic       pulse_lvl_ff, sens_lvl_ff, min_lvl_ff, pulse_prev_ff;
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_pulse_ff <= 3'h0;
      s_sens_ff  <= 3'h0;
      s_min_ff   <= 3'h0;
      pulse_lvl_ff <= 1'b0;
      sens_lvl_ff  <= 1'b0;
      min_lvl_ff   <= 1'b0;
      pulse_prev_ff <= 1'b0;
    end else begin
      s_pulse_ff <= {s_pulse_ff[1:0], pulse_in};
      s_sens_ff  <= {s_sens_ff[1:0], sensor_in};
      s_min_ff   <= {s_min_ff[1:0], min_level_in};
      if (s_pulse_ff[1] == s_pulse_ff[2]) pulse_lvl_ff <= s_pulse_ff[2];
      if (s_sens_ff[1] == s_sens_ff[2])   sens_lvl_ff  <= s_sens_ff[2];
      if (s_min_ff[1] == s_min_ff[2])     min_lvl_ff   <= s_min_ff[2];
      pulse_prev_ff <= pulse_lvl_ff;
    end
  end
  wire pulse_edge = pulse_lvl_ff && !pulse_prev_ff;

  // one-second tick and phase counters
  logic [31:0] tick_ff;
  logic [23:0] sec_ff;
  logic [15:0] pcnt_ff;
  logic [7:0]  done_ff, pre_left_ff;
  logic        pre_ff, started_ff;
  lcs_pkg::lcs_state_type state_ff, nxt_state;
  wire tick = (tick_ff == SEC_CYC - 1);
  always_ff @(posedge mclk) begin
    if (reset || state_ff != nxt_state) tick_ff <= 32'h0;
    else tick_ff <= tick ? 32'h0 : tick_ff + 32'h1;
  end

  // phase end conditions
  wire pulse_mode = (end_ff == lcs_pkg::LCS_END_PULSE);
  wire pause_up   = (sec_ff >= pause_s_ff);
  wire sb_cnt_up  = (pcnt_ff >= pcnt_sb_ff);
  logic sb_end, cyc_end, tout_hit, sb_tout;
  always_comb begin
    sb_tout = 1'b0;
    // RQ2 pulse standby
    if (pulse_mode) sb_end = sb_cnt_up;
    else begin
      // RQ4 standby source
      case (sb_ff)
        lcs_pkg::LCS_SB_TIMER: sb_end = pause_up;
        // RQ5 first wins
        lcs_pkg::LCS_SB_BOTH:  sb_end = pause_up || sb_cnt_up;
        // RQ6 count only
        lcs_pkg::LCS_SB_COUNT: sb_end = sb_cnt_up;
        // RQ7 count with alarm
        lcs_pkg::LCS_SB_CNT_TOUT: begin
          sb_end  = sb_cnt_up;
          sb_tout = pause_up && !sb_cnt_up;
        end
        default: sb_end = pause_up;
      endcase
    end
    // RQ3 monitor choice
    if (pulse_mode)
      cyc_end = (pcnt_ff >= pcnt_lube_ff)
                && (mon_ff == lcs_pkg::LCS_MON_TIMER || sens_lvl_ff);
    else if (mon_ff == lcs_pkg::LCS_MON_PS)
      // RQ1 sensor confirms
      cyc_end = sens_lvl_ff;
    else
      // RQ9 timed run
      cyc_end = (sec_ff >= 24'(lube_s_ff));
    // RQ8 timeout check
    tout_hit = !cyc_end && (sec_ff >= 24'(tout_s_ff))
               && !(mon_ff == lcs_pkg::LCS_MON_TIMER && !pulse_mode);
  end

  // alarm codes: 1 low level, 5 cycle timeout, 8 pause timeout
  wire [3:0] alarm_code = min_lvl_ff ? 4'h1 : irq_st_ff[1] ? 4'h5 : irq_st_ff[2] ? 4'h8 : 4'h0;
  // RQ17 halt policy
  wire halt_req = (halt_ff == lcs_pkg::LCS_HALT_ALL && alarm_code != 4'h0)
               || (halt_ff == lcs_pkg::LCS_HALT_NOT_MIN && (irq_st_ff[2:1] != 2'h0));

  // phase state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      lcs_pkg::LCS_ST_STANDBY: if (halt_req) nxt_state = lcs_pkg::LCS_ST_HALT;
                               else if (sb_end) nxt_state = lcs_pkg::LCS_ST_LUBE;
      lcs_pkg::LCS_ST_LUBE:    if (halt_req) nxt_state = lcs_pkg::LCS_ST_HALT;
                               else if (cyc_end) nxt_state = lcs_pkg::LCS_ST_DWELL;
      lcs_pkg::LCS_ST_DWELL:   nxt_state = (pre_ff ? (pre_left_ff <= 8'h1)
                                 : (done_ff + 8'h1 >= cycles_ff))
                                 ? lcs_pkg::LCS_ST_STANDBY : lcs_pkg::LCS_ST_LUBE;
      lcs_pkg::LCS_ST_HALT:    if (!halt_req) nxt_state = lcs_pkg::LCS_ST_STANDBY;
      default:                 nxt_state = lcs_pkg::LCS_ST_STANDBY;
    endcase
  end

  // state, seconds, pulse and cycle counters
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= lcs_pkg::LCS_ST_STANDBY;
      sec_ff <= 24'h0;
      pcnt_ff <= 16'h0;
      done_ff <= 8'h0;
      pre_left_ff <= 8'h0;
      pre_ff <= 1'b0;
      started_ff <= 1'b0;
    end else if (!started_ff) begin
      // power-on phase chosen once, after the release of reset
      started_ff <= 1'b1;
      pre_left_ff <= prelube_ff;
      // RQ13 prelube first
      pre_ff <= (prelube_ff != 8'h0);
      // RQ11 power-on phase
      if (prelube_ff != 8'h0 || po_ff == lcs_pkg::LCS_PO_LUBE)
        state_ff <= lcs_pkg::LCS_ST_LUBE;
      else if (po_ff == lcs_pkg::LCS_PO_RESUME && held_valid) begin
        // RQ12 resume progress
        state_ff <= held_lube ? lcs_pkg::LCS_ST_LUBE : lcs_pkg::LCS_ST_STANDBY;
        done_ff  <= (held_cycles >= cycles_ff) ? 8'h0 : held_cycles;
      end
    end else begin
      state_ff <= nxt_state;
      if (state_ff != nxt_state) begin
        sec_ff <= 24'h0;
        pcnt_ff <= 16'h0;
      end else begin
        if (tick && sec_ff != 24'hffffff) sec_ff <= sec_ff + 24'h1;
        if (pulse_edge && pcnt_ff != 16'hffff) pcnt_ff <= pcnt_ff + 16'h1;
      end
      // RQ10 cycle repeat
      if (state_ff == lcs_pkg::LCS_ST_DWELL) begin
        if (pre_ff) begin
          pre_left_ff <= pre_left_ff - 8'h1;
          if (pre_left_ff <= 8'h1) pre_ff <= 1'b0;
        end else begin
          done_ff <= (nxt_state == lcs_pkg::LCS_ST_STANDBY) ? 8'h0 : done_ff + 8'h1;
        end
      end
    end
  end

  // RQ18 pump drive
  always_ff @(posedge mclk) begin
    if (reset) pump_on <= 1'b0;
    else pump_on <= (nxt_state == lcs_pkg::LCS_ST_LUBE) && started_ff;
  end

  // sticky events: 0 low level, 1 cycle timeout, 2 pause timeout, 3 phase done
  wire [3:0] ev = {state_ff == lcs_pkg::LCS_ST_DWELL && nxt_state == lcs_pkg::LCS_ST_STANDBY,
                   state_ff == lcs_pkg::LCS_ST_STANDBY && sb_tout,
                   state_ff == lcs_pkg::LCS_ST_LUBE && tout_hit,
                   min_lvl_ff};
  always_ff @(posedge mclk) begin
    if (reset) irq_st_ff <= 4'h0;
    // set wins over a simultaneous clear
    else irq_st_ff <= (irq_st_ff & ~((wr && addr == R_IRQ_CLR) ? wdata[3:0] : 4'h0)) | ev;
  end
  assign irq = |(irq_st_ff & irq_en_ff);

  // read port: data in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (reset || !rd) rdata <= 32'h0;
    else case (addr)
      R_MODE:   rdata <= {23'h0, coded_ff, halt_ff, po_ff, sb_ff, mon_ff, end_ff};
      R_PAUSE:  rdata <= {8'h0, pause_s_ff};
      R_TIMES:  rdata <= {17'h0, lube_s_ff, 1'b0, tout_s_ff};
      R_COUNTS: rdata <= {16'h0, prelube_ff, cycles_ff};
      R_PCNT:   rdata <= {pcnt_lube_ff, pcnt_sb_ff};
      R_STATUS: rdata <= {alarm_code, pre_ff, pump_on, state_ff, done_ff, pcnt_ff};
      R_IRQ_ST: rdata <= {28'h0, irq_st_ff};
      R_IRQ_EN: rdata <= {28'h0, irq_en_ff};
      default:  rdata <= 32'h0;
    endcase
  end

  lcs_alarm_coder #(.BURST_CYC(BURST_CYC), .GAP_CYC(GAP_CYC)) u_alarm (
    .mclk       (mclk),
    .reset      (reset),
    .coded_mode (coded_ff),
    .alarm_code (alarm_code),
    .relay_on   (alarm_relay)
  );

  // RQ18 pump off in standby
  chk_pump_standby: assert property (@(posedge mclk) disable iff (reset)
    state_ff == lcs_pkg::LCS_ST_STANDBY && $past(state_ff) == lcs_pkg::LCS_ST_STANDBY
    |-> !pump_on) else $error("pump on in standby"); // RQ18
  // RQ17 halt stops pump
  chk_halt_pump: assert property (@(posedge mclk) disable iff (reset)
    state_ff == lcs_pkg::LCS_ST_HALT |=> !pump_on) else $error("pump on while halted"); // RQ17
  // RQ14 steady relay
  chk_relay_std: assert property (@(posedge mclk) disable iff (reset)
    !coded_ff && alarm_code != 4'h0 |=> !alarm_relay) else $error("relay on in alarm"); // RQ14
  // RQ6 count ignores timer
  chk_count_only: assert property (@(posedge mclk) disable iff (reset)
    state_ff == lcs_pkg::LCS_ST_STANDBY && !pulse_mode && sb_ff == lcs_pkg::LCS_SB_COUNT
    && !sb_cnt_up && !halt_req && started_ff |=> state_ff == lcs_pkg::LCS_ST_STANDBY)
    else $error("standby left early"); // RQ6
  // RQ9 timed run length
  chk_timed_run: assert property (@(posedge mclk) disable iff (reset)
    state_ff == lcs_pkg::LCS_ST_LUBE && !pulse_mode && mon_ff == lcs_pkg::LCS_MON_TIMER
    && sec_ff < 24'(lube_s_ff) && !halt_req |=> state_ff == lcs_pkg::LCS_ST_LUBE)
    else $error("run cut short"); // RQ9
  // RQ8 timeout sets flag
  chk_tout_flag: assert property (@(posedge mclk) disable iff (reset)
    state_ff == lcs_pkg::LCS_ST_LUBE && tout_hit |=> irq_st_ff[1])
    else $error("timeout not flagged"); // RQ8
  // RQ5 either ends standby
  chk_both_end: assert property (@(posedge mclk) disable iff (reset)
    state_ff == lcs_pkg::LCS_ST_STANDBY && !pulse_mode && sb_ff == lcs_pkg::LCS_SB_BOTH
    && (pause_up || sb_cnt_up) && !halt_req && started_ff
    |=> state_ff == lcs_pkg::LCS_ST_LUBE) else $error("standby not ended"); // RQ5
  // RQ10 phase ends after count
  chk_cycle_cnt: assert property (@(posedge mclk) disable iff (reset)
    state_ff == lcs_pkg::LCS_ST_DWELL && !pre_ff && done_ff + 8'h1 >= cycles_ff
    |=> state_ff == lcs_pkg::LCS_ST_STANDBY && done_ff == 8'h0)
    else $error("phase not ended"); // RQ10
  cov_phase_done: cover property (@(posedge mclk) disable iff (reset) ev[3]);
  cov_timeout: cover property (@(posedge mclk) disable iff (reset) ev[1]);
  cov_halt: cover property (@(posedge mclk) disable iff (reset)
    state_ff == lcs_pkg::LCS_ST_HALT);
endmodule : lcs_sequencer
`default_nettype wire

/* File: sim/lcs_far_side.sv */
// far side model: pulse source, cycle sensor and remote alarm monitor
`timescale 1ns/10ps
`default_nettype none
module lcs_far_side #(
  parameter int BURST_CYC = 5,
  parameter int GAP_CYC   = 20
) (
  input  wire logic mclk,
  input  wire logic pump_on,
  input  wire logic alarm_relay,
  output logic      pulse_in,
  output logic      sensor_in
);
  int sens_delay = 3;
  int on_cnt     = 0;
  int low_len    = 0;
  int high_len   = 0;
  int bursts     = 0;
  int last_code  = 0;
  int burst_bad  = 0;

  initial begin
    pulse_in = 1'b0;
    sensor_in = 1'b0;
  end

  // external pulses
  // four cycles high, four low, so the three-flop sync never misses one
  task automatic send(input int n);
    repeat (n) begin
      pulse_in <= 1'b1;
      repeat (4) @(posedge mclk);
      pulse_in <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask : send

  // sensor confirms cycle
  // zero delay means the switch never closes; it opens as the pump stops
  always @(posedge mclk) begin
    on_cnt <= pump_on ? on_cnt + 1 : 0;
    sensor_in <= pump_on && sens_delay != 0 && on_cnt >= sens_delay;
  end

  // count coded bursts
  // a long high stretch closes a code; odd burst lengths are tallied
  always @(posedge mclk) begin
    if (!alarm_relay) begin
      low_len <= low_len + 1;
      high_len <= 0;
    end else begin
      if (low_len != 0) begin
        bursts <= bursts + 1;
        if (low_len != BURST_CYC) burst_bad <= burst_bad + 1;
      end
      low_len <= 0;
      high_len <= high_len + 1;
      if (high_len == GAP_CYC - 2) begin
        last_code <= bursts;
        bursts <= 0;
      end
    end
  end
endmodule : lcs_far_side
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the lubrication cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        mclk;
  logic        reset;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        pulse_in;
  logic        sensor_in;
  logic        min_level_in;
  logic        held_lube;
  logic        held_valid;
  logic [7:0]  held_cycles;
  logic        pump_on;
  logic        alarm_relay;
  logic        irq;
  logic        rd_q = 1'b0;
  logic [63:0] nt;
  logic [63:0] notes[$];
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          t;
  int          k;
  int          nsb;

  lcs_sequencer #(.SEC_CYC(20), .BURST_CYC(5), .GAP_CYC(20)) i_dut (
    .mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pulse_in(pulse_in), .sensor_in(sensor_in),
    .min_level_in(min_level_in), .held_valid(held_valid), .held_lube(held_lube),
    .held_cycles(held_cycles), .pump_on(pump_on), .alarm_relay(alarm_relay), .irq(irq));

  lcs_far_side #(.BURST_CYC(5), .GAP_CYC(20)) i_far (
    .mclk(mclk), .pump_on(pump_on), .alarm_relay(alarm_relay),
    .pulse_in(pulse_in), .sensor_in(sensor_in));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  // a hang counts as a mismatch
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  // read data stand one cycle only, so compare exactly there
  always @(posedge mclk) begin
    rd_q <= rd;
    if (rd_q) begin
      nt = notes.pop_front();
      chk(rdata & nt[63:32], nt[31:0]);
    end
  end

  // outputs are looked at 1 ns after the edge, once they have settled
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    tick();
    wr <= 1'b0;
    tick();
  endtask : wreg

  task automatic rreg(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    notes.push_back({m, e & m});
    addr <= a;
    rd <= 1'b1;
    tick();
    rd <= 1'b0;
    tick();
  endtask : rreg

  task automatic wpump(input logic v, input int lim);
    for (int n = 0; pump_on !== v && n < lim; n++) tick();
  endtask : wpump

  task automatic wirq(input int lim);
    for (int n = 0; irq !== 1'b1 && n < lim; n++) tick();
  endtask : wirq

  task automatic ontime(output int len);
    wpump(1'b1, 9000);
    len = 0;
    while (pump_on === 1'b1 && len < 9000) begin
      tick();
      len++;
    end
  endtask : ontime

  // retained progress is random; with one programmed cycle it restarts at zero
  task automatic do_reset(input logic lube, input logic valid);
    held_lube <= lube;
    held_valid <= valid;
    held_cycles <= 8'($urandom);
    reset <= 1'b1;
    repeat (10) tick();
    reset <= 1'b0;
    tick();
  endtask : do_reset

  initial begin
    reset = 1'b1;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    min_level_in = 1'b0;
    held_lube = 1'b1;
    k = $urandom(11);
    do_reset(1'b1, 1'b1);
    wpump(1'b1, 10);
    chk({31'h0, pump_on}, 32'h1);
    rreg(4'h5, 32'h03ff_0000, 32'h0100_0000);
    rreg(4'h0, 32'h1ff, 32'h0);
    rreg(4'h1, 32'hff_ffff, 32'd360);
    rreg(4'h2, 32'h7f7f, 32'h1e1e);
    rreg(4'h3, 32'hffff, 32'h0001);
    rreg(4'hb, 32'hffff_ffff, 32'h0);
    wreg(4'h3, 32'hffff);
    rreg(4'h3, 32'hffff, 32'hfafa);
    wreg(4'h2, 32'h7f00);
    rreg(4'h2, 32'h7f7f, 32'h7801);
    chk({31'h0, alarm_relay}, 32'h1);
    // held phase says lube, but it is not marked valid: standby expected
    do_reset(1'b1, 1'b0);
    chk({31'h0, pump_on}, 32'h0);
    // timed cycles: two of three seconds each, then a three second pause
    wreg(4'h1, 32'd3);
    wreg(4'h2, 32'h0305);
    wreg(4'h3, 32'h2);
    wreg(4'h8, 32'h8);
    wreg(4'h7, 32'hf);
    wirq(9000);
    wreg(4'h7, 32'h8);
    ontime(t);
    chk({31'h0, t > 56 && t < 64}, 32'h1);
    tick();
    tick();
    chk({31'h0, irq}, 32'h0);
    ontime(t);
    chk({31'h0, t > 56 && t < 64}, 32'h1);
    wirq(10);
    chk({31'h0, irq}, 32'h1);
    wreg(4'h8, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wpump(1'b1, 40);
    chk({31'h0, pump_on}, 32'h0);
    wreg(4'h7, 32'h8);
    // pressure switch monitoring with a two second timeout
    wreg(4'h0, 32'h2);
    wreg(4'h2, 32'h0302);
    wreg(4'h3, 32'h1);
    wreg(4'h8, 32'h2);
    i_far.sens_delay = 5 + $urandom % 10;
    ontime(t);
    ontime(t);
    chk({31'h0, t < i_far.sens_delay + 12}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    i_far.sens_delay = 0;
    ontime(t);
    chk({31'h0, t > 37 && t < 45}, 32'h1);
    wirq(5);
    chk({31'h0, irq}, 32'h1);
    rreg(4'h5, 32'hf000_0000, 32'h5000_0000);
    chk({31'h0, alarm_relay}, 32'h0);
    wpump(1'b1, 150);
    chk({31'h0, pump_on}, 32'h0);
    // coded relay while the timeout alarm stands
    wreg(4'h0, 32'h102);
    repeat (100) tick();
    i_far.burst_bad = 0;
    repeat (150) tick();
    chk(i_far.last_code, 32'd5);
    chk(i_far.burst_bad, 32'd0);
    i_far.sens_delay = 8;
    wreg(4'h7, 32'hf);
    tick();
    chk({31'h0, alarm_relay}, 32'h1);
    ontime(t);
    chk({31'h0, t < 20}, 32'h1);
    // halt policy none keeps cycling after a timeout
    wreg(4'h0, 32'h42);
    i_far.sens_delay = 0;
    wirq(300);
    chk({31'h0, irq}, 32'h1);
    wpump(1'b0, 60);
    wpump(1'b1, 200);
    chk({31'h0, pump_on}, 32'h1);
    // low level spares the pump under all-but-minimum, not under halt all
    i_far.sens_delay = 8;
    // let the running cycle end first, or its timeout flag re-sets over the clear
    wpump(1'b0, 60);
    wreg(4'h7, 32'hf);
    wreg(4'h0, 32'h82);
    wreg(4'h8, 32'h1);
    min_level_in <= 1'b1;
    wirq(20);
    chk({31'h0, irq}, 32'h1);
    wpump(1'b0, 100);
    wpump(1'b1, 200);
    chk({31'h0, pump_on}, 32'h1);
    wreg(4'h0, 32'h2);
    wpump(1'b0, 100);
    wpump(1'b1, 200);
    chk({31'h0, pump_on}, 32'h0);
    min_level_in <= 1'b0;
    // the synchronised level lags the pin; a clear before it falls is lost
    repeat (6) tick();
    wreg(4'h7, 32'hf);
    // pulse mode: both phases counted
    nsb = 2 + $urandom % 3;
    wreg(4'h4, 32'h0003_0000 | nsb);
    wreg(4'h0, 32'h1);
    for (k = 0; pump_on !== 1'b1 && k < 12; k++) i_far.send(1);
    chk({31'h0, pump_on}, 32'h1);
    i_far.send(2);
    chk({31'h0, pump_on}, 32'h1);
    i_far.send(1);
    wpump(1'b0, 10);
    chk({31'h0, pump_on}, 32'h0);
    i_far.send(nsb - 1);
    repeat (6) tick();
    chk({31'h0, pump_on}, 32'h0);
    i_far.send(1);
    wpump(1'b1, 10);
    chk({31'h0, pump_on}, 32'h1);
    i_far.send(3);
    // standby by count ignores the pause timer
    wreg(4'h1, 32'd2);
    wreg(4'h4, 32'h2);
    wreg(4'h0, 32'h8);
    wpump(1'b0, 100);
    wpump(1'b1, 150);
    chk({31'h0, pump_on}, 32'h0);
    i_far.send(2);
    wpump(1'b1, 10);
    chk({31'h0, pump_on}, 32'h1);
    wreg(4'h0, 32'hc);
    wreg(4'h8, 32'h4);
    ontime(t);
    wirq(60);
    chk({31'h0, irq}, 32'h1);
    rreg(4'h5, 32'hf000_0000, 32'h8000_0000);
    wreg(4'h0, 32'h4);
    wreg(4'h7, 32'hf);
    wpump(1'b1, 60);
    chk({31'h0, pump_on}, 32'h1);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
